// ==== hdl/ccs_map.vh ====
// Constants for the cache coherency state updater
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ==========================================================
// Coherency state codes
`define CCS_ST_I         2'h0
`define CCS_ST_S         2'h1
`define CCS_ST_E         2'h2
`define CCS_ST_M         2'h3

// ==========================================================
// Address fields
`define CCS_TAG_W        27
`define CCS_LINE_OFS_W   5
`define CCS_PAGE_W       20
`define CCS_PAGE_MSB     26
`define CCS_PAGE_LSB     7
`define CCS_A20_BIT      20

// ==========================================================
// Sweep modes
`define CCS_MD_FLUSH     3'h0
`define CCS_MD_WBINV     3'h1
`define CCS_MD_INV       3'h2
`define CCS_MD_PAGE_WB   3'h3
`define CCS_MD_PAGE_INV  3'h4
`define CCS_MD_EVICT     3'h5

// ==========================================================
// Level cleared when a writeback is acknowledged
`define CCS_CLR_NONE     2'h0
`define CCS_CLR_L1D      2'h1
`define CCS_CLR_L2       2'h2

// ==========================================================
// Reset values
`define CCS_RST_PF       1'h0
`define CCS_SYNC_RST     1'h1

`endif

// ==== hdl/ccs_sync2.v ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_sync2 #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_q;

  // ==========================================================
  // Synchroniser flops
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{`CCS_SYNC_RST}};
      dout   <= {W{`CCS_SYNC_RST}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ==== hdl/ccs_core.v ====
// Coherency state updater for split L1 and unified L2 caches
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_core #(
  parameter LINES = 8,
  parameter IW    = 3
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Pins
  input  wire        flush_n,
  input  wire        addr_bit20_mask_n,
  // Processor access
  input  wire        acc_valid,
  input  wire        acc_write,
  input  wire        acc_instr,
  input  wire [31:0] acc_addr,
  output reg         acc_done,
  // Page register write
  input  wire        page_flush_register_wr,
  input  wire [19:0] linear_page_number,
  input  wire        page_fi,
  input  wire        page_xlate_fault,
  output reg         page_fault_flag,
  // Whole-cache instructions
  input  wire        writeback_invalidate_all_instr,
  input  wire        invalidate_all_instr,
  output reg         op_done,
  output reg         idle,
  // System bus
  output reg         bus_req,
  output reg         bus_wr,
  output reg         bus_burst,
  output reg  [31:0] bus_addr,
  input  wire        bus_ack
);

  localparam S_IDLE = 3'h0;
  localparam S_STEP = 3'h1;
  localparam S_BUS  = 3'h2;
  localparam S_FILL = 3'h3;
  localparam S_LOAD = 3'h4;

  // ==========================================================
  // Line storage
  reg [`CCS_TAG_W-1:0] tag_q [0:LINES-1];
  reg [1:0]            l1d_q [0:LINES-1];
  reg                  l1i_q [0:LINES-1];
  reg [1:0]            l2_q  [0:LINES-1];

  reg [2:0]            st_q;
  reg [2:0]            ret_q;
  reg [2:0]            mode_q;
  reg [IW-1:0]         idx_q;
  reg [IW-1:0]         victim_q;
  reg [1:0]            clr_q;
  reg [19:0]           page_q;
  reg [31:0]           addr_q;
  reg                  instr_q;
  reg                  flush_prev_q;
  integer              k;

  // ==========================================================
  // Pin synchronisers
  wire [1:0] pins_s;
  ccs_sync2 #(.W(2)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({flush_n, addr_bit20_mask_n}),
    .dout (pins_s)
  );
  wire flush_act = ~pins_s[1];
  wire a20_act   = ~pins_s[0];

  // ==========================================================
  // Lookup helpers
  function [31:0] mask_a20;
    input [31:0] a;
    input        m;
    begin
      mask_a20 = a;
      if (m)
        mask_a20[`CCS_A20_BIT] = 1'b0;
    end
  endfunction

  function [IW:0] find;
    input [`CCS_TAG_W-1:0] t;
    integer                i;
    begin
      find = {(IW+1){1'b0}};
      for (i = 0; i < LINES; i = i + 1) begin
        if (!find[IW] && tag_q[i] == t &&
            (l1d_q[i] != `CCS_ST_I || l1i_q[i] || l2_q[i] != `CCS_ST_I))
          find = {1'b1, i[IW-1:0]};
      end
    end
  endfunction

  wire [31:0]           acc_m   = mask_a20(acc_addr, a20_act);
  wire [IW:0]           lk      = find(acc_m[31:`CCS_LINE_OFS_W]);
  wire                  hit     = lk[IW];
  wire [IW-1:0]         hi      = lk[IW-1:0];
  wire [1:0]            h_l1d   = l1d_q[hi];
  wire [1:0]            h_l2    = l2_q[hi];
  wire [1:0]            c_l1d   = l1d_q[idx_q];
  wire [1:0]            c_l2    = l2_q[idx_q];
  wire [`CCS_TAG_W-1:0] c_tag   = tag_q[idx_q];
  wire                  c_page  = c_tag[`CCS_PAGE_MSB:`CCS_PAGE_LSB] == page_q;
  wire                  in_scope = (mode_q == `CCS_MD_PAGE_WB || mode_q == `CCS_MD_PAGE_INV) ?
                                   c_page : (mode_q == `CCS_MD_EVICT ? 1'b1 : 1'b1);
  wire                  do_wb   = mode_q != `CCS_MD_INV && mode_q != `CCS_MD_PAGE_INV;
  wire [31:0]           idx_w   = {{(32-IW){1'b0}}, idx_q};
  wire                  last    = idx_w == LINES - 1;

  // ==========================================================
  // Control
  always @(posedge clk) begin
    if (rst) begin
      st_q            <= S_IDLE;
      ret_q           <= S_IDLE;
      mode_q          <= `CCS_MD_FLUSH;
      idx_q           <= {IW{1'b0}};
      victim_q        <= {IW{1'b0}};
      clr_q           <= `CCS_CLR_NONE;
      page_q          <= 20'h00000;
      addr_q          <= 32'h00000000;
      instr_q         <= 1'b0;
      flush_prev_q    <= 1'b0;
      acc_done        <= 1'b0;
      op_done         <= 1'b0;
      idle            <= 1'b1;
      page_fault_flag <= `CCS_RST_PF;
      bus_req         <= 1'b0;
      bus_wr          <= 1'b0;
      bus_burst       <= 1'b0;
      bus_addr        <= 32'h00000000;
      for (k = 0; k < LINES; k = k + 1) begin
        tag_q[k] <= {`CCS_TAG_W{1'b0}};
        l1d_q[k] <= `CCS_ST_I;
        l1i_q[k] <= 1'b0;
        l2_q[k]  <= `CCS_ST_I;
      end
    end else begin
      acc_done     <= 1'b0;
      op_done      <= 1'b0;
      flush_prev_q <= flush_act;
      case (st_q)
        S_IDLE: begin
          if (flush_act && !flush_prev_q) begin
            mode_q <= `CCS_MD_FLUSH;
            idx_q  <= {IW{1'b0}};
            st_q   <= S_STEP;
            idle   <= 1'b0;
          end else if (writeback_invalidate_all_instr || invalidate_all_instr) begin
            mode_q <= writeback_invalidate_all_instr ? `CCS_MD_WBINV : `CCS_MD_INV;
            idx_q  <= {IW{1'b0}};
            st_q   <= S_STEP;
            idle   <= 1'b0;
          end else if (page_flush_register_wr) begin
            page_fault_flag <= page_xlate_fault;
            if (page_xlate_fault) begin
              op_done <= 1'b1;
            end else begin
              mode_q <= page_fi ? `CCS_MD_PAGE_INV : `CCS_MD_PAGE_WB;
              page_q <= linear_page_number;
              idx_q  <= {IW{1'b0}};
              st_q   <= S_STEP;
              idle   <= 1'b0;
            end
          end else if (acc_valid) begin
            addr_q  <= acc_m;
            instr_q <= acc_instr;
            if (acc_write) begin
              if (hit && (h_l1d == `CCS_ST_M || h_l1d == `CCS_ST_E)) begin
                l1d_q[hi] <= `CCS_ST_M;
                acc_done  <= 1'b1;
              end else begin
                if (hit && h_l1d == `CCS_ST_I)
                  l1i_q[hi] <= 1'b0;
                bus_req   <= 1'b1;
                bus_wr    <= 1'b1;
                bus_burst <= 1'b0;
                bus_addr  <= acc_m;
                clr_q     <= `CCS_CLR_NONE;
                ret_q     <= S_IDLE;
                st_q      <= S_BUS;
                idle      <= 1'b0;
              end
            end else if (!acc_instr) begin
              if (hit && h_l1d != `CCS_ST_I) begin
                acc_done <= 1'b1;
              end else if (hit) begin
                l1i_q[hi] <= 1'b0;
                if (h_l2 != `CCS_ST_I) begin
                  l1d_q[hi] <= (h_l2 == `CCS_ST_M) ? `CCS_ST_M : h_l2;
                  if (h_l2 == `CCS_ST_M)
                    l2_q[hi] <= `CCS_ST_E;
                  acc_done <= 1'b1;
                end else begin
                  idx_q <= hi;
                  st_q  <= S_FILL;
                  idle  <= 1'b0;
                end
              end else begin
                idx_q    <= victim_q;
                victim_q <= victim_q + 1'b1;
                mode_q   <= `CCS_MD_EVICT;
                st_q     <= S_STEP;
                idle     <= 1'b0;
              end
            end else begin
              if (hit && l1i_q[hi]) begin
                acc_done <= 1'b1;
              end else if (hit) begin
                idx_q <= hi;
                if (h_l1d == `CCS_ST_M && h_l2 == `CCS_ST_E) begin
                  l1d_q[hi] <= `CCS_ST_I;
                  l2_q[hi]  <= `CCS_ST_M;
                  l1i_q[hi] <= 1'b1;
                  acc_done  <= 1'b1;
                end else if (h_l1d == `CCS_ST_M) begin
                  bus_req   <= 1'b1;
                  bus_wr    <= 1'b1;
                  bus_burst <= 1'b1;
                  bus_addr  <= {tag_q[hi], 5'h00};
                  clr_q     <= `CCS_CLR_L1D;
                  ret_q     <= S_FILL;
                  st_q      <= S_BUS;
                  idle      <= 1'b0;
                end else begin
                  l1d_q[hi] <= `CCS_ST_I;
                  if (h_l2 != `CCS_ST_I) begin
                    l1i_q[hi] <= 1'b1;
                    acc_done  <= 1'b1;
                  end else begin
                    st_q <= S_FILL;
                    idle <= 1'b0;
                  end
                end
              end else begin
                idx_q    <= victim_q;
                victim_q <= victim_q + 1'b1;
                mode_q   <= `CCS_MD_EVICT;
                st_q     <= S_STEP;
                idle     <= 1'b0;
              end
            end
          end
        end
        S_STEP: begin
          if (in_scope && do_wb && c_l1d == `CCS_ST_M) begin
            bus_req   <= 1'b1;
            bus_wr    <= 1'b1;
            bus_burst <= 1'b1;
            bus_addr  <= {c_tag, 5'h00};
            clr_q     <= `CCS_CLR_L1D;
            ret_q     <= S_STEP;
            st_q      <= S_BUS;
          end else if (in_scope && do_wb && c_l2 == `CCS_ST_M) begin
            bus_req   <= 1'b1;
            bus_wr    <= 1'b1;
            bus_burst <= 1'b1;
            bus_addr  <= {c_tag, 5'h00};
            clr_q     <= `CCS_CLR_L2;
            ret_q     <= S_STEP;
            st_q      <= S_BUS;
          end else begin
            if (in_scope) begin
              l1d_q[idx_q] <= `CCS_ST_I;
              l1i_q[idx_q] <= 1'b0;
              l2_q[idx_q]  <= `CCS_ST_I;
            end
            if (mode_q == `CCS_MD_EVICT) begin
              st_q <= S_FILL;
            end else if (last) begin
              st_q    <= S_IDLE;
              idle    <= 1'b1;
              op_done <= 1'b1;
            end else begin
              idx_q <= idx_q + 1'b1;
            end
          end
        end
        S_FILL: begin
          tag_q[idx_q] <= addr_q[31:`CCS_LINE_OFS_W];
          bus_req      <= 1'b1;
          bus_wr       <= 1'b0;
          bus_burst    <= 1'b1;
          bus_addr     <= {addr_q[31:`CCS_LINE_OFS_W], 5'h00};
          clr_q        <= `CCS_CLR_NONE;
          ret_q        <= S_LOAD;
          st_q         <= S_BUS;
        end
        S_LOAD: begin
          if (instr_q)
            l1i_q[idx_q] <= 1'b1;
          else
            l1d_q[idx_q] <= `CCS_ST_E;
          l2_q[idx_q] <= `CCS_ST_E;
          acc_done    <= 1'b1;
          st_q        <= S_IDLE;
          idle        <= 1'b1;
        end
        S_BUS: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            if (clr_q == `CCS_CLR_L1D)
              l1d_q[idx_q] <= `CCS_ST_I;
            else if (clr_q == `CCS_CLR_L2)
              l2_q[idx_q] <= `CCS_ST_I;
            st_q <= ret_q;
            if (ret_q == S_IDLE) begin
              acc_done <= 1'b1;
              idle     <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
          idle <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== testbench/ccs_checker.sv ====
// Assertion checker for the coherency state updater ports
`timescale 1ns/1ps
module ccs_checker #(
  parameter LINES = 8,
  parameter IW    = 3
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Pins and requests
  input wire        flush_n,
  input wire        addr_bit20_mask_n,
  input wire        acc_valid,
  input wire        acc_write,
  input wire        acc_instr,
  input wire [31:0] acc_addr,
  input wire        acc_done,
  input wire        page_flush_register_wr,
  input wire [19:0] linear_page_number,
  input wire        page_fi,
  input wire        page_xlate_fault,
  input wire        page_fault_flag,
  input wire        writeback_invalidate_all_instr,
  input wire        invalidate_all_instr,
  input wire        op_done,
  input wire        idle,
  // System bus
  input wire        bus_req,
  input wire        bus_wr,
  input wire        bus_burst,
  input wire [31:0] bus_addr,
  input wire        bus_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Pin history
  logic [2:0] flush_hist_q;
  logic [3:0] mask_hist_q;
  wire        pin_quiet = flush_n && (&flush_hist_q);
  always @(posedge clk) begin
    if (rst) begin
      flush_hist_q <= 3'h0;
      mask_hist_q  <= 4'hf;
    end else begin
      flush_hist_q <= {flush_hist_q[1:0], flush_n};
      mask_hist_q  <= {mask_hist_q[2:0], addr_bit20_mask_n};
    end
  end

  // ==========================================================
  // Request sequences
  sequence invalidate_all_instr_taken;
    idle && pin_quiet && invalidate_all_instr && !writeback_invalidate_all_instr;
  endsequence
  sequence page_taken;
    idle && pin_quiet && page_flush_register_wr && !writeback_invalidate_all_instr && !invalidate_all_instr;
  endsequence

  // ==========================================================
  // Assertions
  a_bus_hold: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_burst))
    else $error("bus cycle changed before acknowledge");
  a_bus_release: assert property (bus_req && bus_ack |=> !bus_req)
    else $error("bus request held after acknowledge");
  a_burst_align: assert property (bus_req && bus_burst |-> bus_addr[4:0] == 5'h0)
    else $error("burst not on a 32-byte line");
  a_wt_single: assert property (bus_req && bus_ack && bus_wr && !bus_burst |=> acc_done)
    else $error("single write did not finish the access");
  a_done_idle: assert property (acc_done || op_done |-> idle)
    else $error("completion without idle");
  a_wt_mask: assert property ($rose(bus_req) && bus_wr && !bus_burst && mask_hist_q == 4'h0
    && !addr_bit20_mask_n |-> !bus_addr[20])
    else $error("writethrough address not masked");
  a_fault_skip: assert property (page_taken ##0 page_xlate_fault |=> op_done && page_fault_flag && !bus_req)
    else $error("faulted page request not skipped");
  a_page_clear: assert property (page_taken ##0 !page_xlate_fault |=> ##[0:300] (op_done && !page_fault_flag))
    else $error("good page request left fault flag set");
  a_invalidate_all_instr_quiet: assert property (invalidate_all_instr_taken |=> (!bus_req)[*8])
    else $error("invalidate-all used the bus");
  a_page_quiet: assert property (page_taken ##0 (page_fi && !page_xlate_fault) |=> (!bus_req)[*8])
    else $error("page invalidate used the bus");
endmodule

// ==== testbench/ccs_bus_model.sv ====
// System bus responder with alternating wait states and a transfer log
`timescale 1ns/1ps
module ccs_bus_model (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // System bus
  input  wire         bus_req,
  input  wire         bus_wr,
  input  wire         bus_burst,
  input  wire  [31:0] bus_addr,
  output logic        bus_ack,
  // Transfer log
  output logic [15:0] wr_cnt,
  output logic [15:0] rd_cnt,
  output logic        last_burst,
  output logic [31:0] last_addr
);
  logic [1:0] wait_q;
  logic       slow_q;
  always @(posedge clk) begin
    if (rst) begin
      bus_ack    <= 1'b0;
      wait_q     <= 2'h0;
      slow_q     <= 1'b0;
      wr_cnt     <= 16'h0;
      rd_cnt     <= 16'h0;
      last_burst <= 1'b0;
      last_addr  <= 32'h0;
    end else if (bus_req && bus_ack) begin
      bus_ack <= 1'b0;
      wait_q  <= 2'h0;
      slow_q  <= ~slow_q;
      if (bus_wr) begin
        wr_cnt     <= wr_cnt + 16'h1;
        last_burst <= bus_burst;
        last_addr  <= bus_addr;
      end else begin
        rd_cnt <= rd_cnt + 16'h1;
      end
    end else if (bus_req) begin
      if (wait_q == {slow_q, 1'b0}) begin
        bus_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the coherency state updater
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    int          kind;
    logic [31:0] addr;
    int          dwr;
    int          drd;
  } ccs_row_t;
  logic        clk = 0, rst = 1, flush_n = 1, addr_bit20_mask_n = 1, acc_valid = 0, acc_write = 0, acc_instr = 0;
  logic        page_flush_register_wr = 0, page_fi = 0, page_xlate_fault = 0;
  logic        writeback_invalidate_all_instr = 0, invalidate_all_instr = 0;
  logic [31:0] acc_addr = 32'h0;
  logic [19:0] linear_page_number = 20'h0;
  logic        acc_done, op_done, idle, page_fault_flag, bus_req, bus_wr, bus_burst, bus_ack, last_burst;
  logic [31:0] bus_addr, last_addr;
  logic [15:0] wr_cnt, rd_cnt, w0, r0;
  int          bad_count = 0, comparisons = 0;
  ccs_row_t    rows [7];
  localparam logic [31:0] LA = 32'h0000_1040, LB = 32'h0000_2080, LC = 32'h0010_3060;

  always #2 clk = ~clk;
  ccs_core #(.LINES(8), .IW(3)) dut (.clk, .rst, .flush_n, .addr_bit20_mask_n, .acc_valid, .acc_write, .acc_instr,
    .acc_addr, .acc_done, .page_flush_register_wr, .linear_page_number, .page_fi, .page_xlate_fault,
    .page_fault_flag, .writeback_invalidate_all_instr, .invalidate_all_instr, .op_done, .idle, .bus_req,
    .bus_wr, .bus_burst, .bus_addr, .bus_ack);
  ccs_bus_model bm (.clk, .rst, .bus_req, .bus_wr, .bus_burst, .bus_addr, .bus_ack, .wr_cnt, .rd_cnt,
    .last_burst, .last_addr);

  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_done(input logic op);
    int n;
    n = 0;
    #1;
    while (((op ? op_done : acc_done) !== 1'b1) && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n < 300), 32'h1);
  endtask
  // Kinds: 0 read, 1 write, 2 fetch, 3 writeback-invalidate, 4 invalidate, 5 page request, 6 flush pin
  task go(input int kind, input logic [31:0] a = 32'h0, input logic f = 1'b0, input logic flt = 1'b0);
    @(posedge clk);
    w0 = wr_cnt;
    r0 = rd_cnt;
    acc_valid <= kind < 3;
    acc_write <= kind == 1;
    acc_instr <= kind == 2;
    acc_addr <= a;
    writeback_invalidate_all_instr <= kind == 3;
    invalidate_all_instr <= kind == 4;
    page_flush_register_wr <= kind == 5;
    linear_page_number <= a[31:12];
    page_fi <= f;
    page_xlate_fault <= flt;
    flush_n <= kind != 6;
    @(posedge clk);
    {acc_valid, writeback_invalidate_all_instr, invalidate_all_instr, page_flush_register_wr} <= 4'h0;
    wait_done(kind > 2);
    if (kind == 6) begin
      @(posedge clk);
      flush_n <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  task bus_chk(input int dwr, input int drd, input logic burst = 1'b0, input logic [31:0] waddr = 32'h0);
    chk(32'(wr_cnt - w0), 32'(dwr));
    chk(32'(rd_cnt - r0), 32'(drd));
    if (dwr > 0) begin
      chk(32'(last_burst), 32'(burst));
      chk(last_addr, waddr);
    end
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    rows = '{'{1, LA, 1, 0}, '{0, LA, 0, 1}, '{0, LA, 0, 0}, '{1, LA, 0, 0}, '{2, LA, 0, 0}, '{0, LA, 0, 0},
      '{1, LA, 0, 0}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'({idle, bus_req, acc_done, op_done, page_fault_flag}), 32'h10);
    $display("reset test done");
    foreach (rows[i]) begin
      go(rows[i].kind, rows[i].addr);
      bus_chk(rows[i].dwr, rows[i].drd, 1'b0, rows[i].addr);
    end
    $display("access table test done");
    go(3);
    bus_chk(1, 0, 1'b1, LA);
    go(0, LA);
    bus_chk(0, 1);
    $display("writeback-invalidate test done");
    go(0, LB);
    go(1, LB);
    go(5, LB);
    bus_chk(1, 0, 1'b1, LB);
    chk(32'(page_fault_flag), 32'h0);
    go(0, LA);
    bus_chk(0, 0);
    go(0, LB);
    bus_chk(0, 1);
    go(1, LB);
    go(5, LB, 1'b1);
    bus_chk(0, 0);
    go(0, LB);
    bus_chk(0, 1);
    $display("page flush test done");
    go(1, LB);
    go(5, LB, 1'b0, 1'b1);
    bus_chk(0, 0);
    chk(32'(page_fault_flag), 32'h1);
    go(0, LB);
    bus_chk(0, 0);
    go(5, LB, 1'b1);
    chk(32'(page_fault_flag), 32'h0);
    $display("page fault test done");
    go(0, LB);
    go(1, LB);
    go(4);
    bus_chk(0, 0);
    go(0, LB);
    bus_chk(0, 1);
    go(1, LB);
    go(6);
    bus_chk(1, 0, 1'b1, LB);
    go(0, LB);
    bus_chk(0, 1);
    $display("invalidate and flush pin test done");
    go(0, LC);
    go(1, LC);
    // Mask only asserted in a stretch standing for real-address mode
    @(posedge clk);
    addr_bit20_mask_n <= 1'b0;
    repeat (4) @(posedge clk);
    go(1, 32'h0010_4000);
    bus_chk(1, 0, 1'b0, 32'h0000_4000);
    go(3);
    bus_chk(1, 0, 1'b1, LC);
    addr_bit20_mask_n <= 1'b1;
    $display("address mask test done");
    print_verdict;
  end

  initial begin
    #80000;
    bad_count++;
    print_verdict;
  end
endmodule

bind ccs_core ccs_checker #(.LINES(LINES), .IW(IW)) chk_i (.clk, .rst, .flush_n, .addr_bit20_mask_n, .acc_valid,
  .acc_write, .acc_instr, .acc_addr, .acc_done, .page_flush_register_wr, .linear_page_number, .page_fi,
  .page_xlate_fault, .page_fault_flag, .writeback_invalidate_all_instr, .invalidate_all_instr, .op_done, .idle,
  .bus_req, .bus_wr, .bus_burst, .bus_addr, .bus_ack);
